// ### design/rlbv_defs.vh
// register offsets, field positions, reset values and decode constants for the config slice
`ifndef RLBV_DEFS_VH
`define RLBV_DEFS_VH

`define RLBV_ADDR_CTRL        8'h11
`define RLBV_ADDR_LIMIT_B     8'h12
`define RLBV_ADDR_LIMIT_C     8'h13
`define RLBV_ADDR_STEP_DROOP  8'h14

`define RLBV_RST_CTRL         8'h22
`define RLBV_RST_LIMIT_B      8'h51
`define RLBV_RST_LIMIT_C      8'h28
`define RLBV_RST_STEP_DROOP   8'h00

`define RLBV_BIT_A_DOUBLE     7
`define RLBV_BIT_B_DOUBLE     6
`define RLBV_BIT_RSVD_ONE     5
`define RLBV_BIT_A_BOOT_EN    4
`define RLBV_BIT_B_BOOT_EN    3
`define RLBV_BIT_C_BOOT_EN    2
`define RLBV_BIT_SLEW_HI      1
`define RLBV_BIT_SLEW_LO      0

`define RLBV_BIT_A_STEP       7
`define RLBV_BIT_B_STEP       6
`define RLBV_BIT_C_STEP       5
`define RLBV_BIT_A_DROOP      4
`define RLBV_BIT_B_DROOP      3
`define RLBV_BIT_C_DROOP      2

`define RLBV_SLEW_CODE0       8'h0a
`define RLBV_SLEW_CODE1       8'h18
`define RLBV_SLEW_CODE2       8'h24
`define RLBV_SLEW_CODE3       8'h30

`define RLBV_STEP_FINE_MV     4'h5
`define RLBV_STEP_COARSE_MV   4'ha

`endif

// ### design/rlbv_regs.v
// rail limit, boot enable, slew and step/droop configuration registers
`timescale 1ns/1ns
`include "rlbv_defs.vh"

module rlbv_regs #(
	parameter ADDR_W  = 8,
	parameter DATA_W  = 8
) (
	// clock and reset
	input  wire              clk,
	input  wire              rst,
	// register access from the serial management engine
	input  wire              wr_en,
	input  wire              rd_en,
	input  wire [ADDR_W-1:0] addr,
	input  wire [DATA_W-1:0] wr_data,
	output reg  [DATA_W-1:0] rd_data,
	output reg               rd_valid,
	// boot voltage values held outside this slice
	input  wire [7:0]        rail_a_boot_value,
	input  wire [7:0]        rail_b_boot_value,
	input  wire [7:0]        rail_c_boot_value,
	// settings to the regulation logic
	output reg  [8:0]        rail_b_limit_amps,
	output reg  [7:0]        rail_c_limit_amps,
	output reg               rail_a_limit_double,
	output reg  [7:0]        rail_a_boot_voltage,
	output reg  [7:0]        rail_b_boot_voltage,
	output reg  [7:0]        rail_c_boot_voltage,
	output reg  [7:0]        fast_slew_mv_per_us,
	output reg  [3:0]        rail_a_step_mv,
	output reg  [3:0]        rail_b_step_mv,
	output reg  [3:0]        rail_c_step_mv,
	output reg               rail_a_flat_droop_en,
	output reg               rail_b_flat_droop_en,
	output reg               rail_c_flat_droop_en
);

	reg [7:0] ctrl_reg;
	reg [7:0] limit_b_reg;
	reg [7:0] limit_c_reg;
	reg [7:0] step_droop_reg;
	reg [7:0] rd_next;

	function [7:0] slew_decode;
		input [1:0] code;
		begin
			case (code)
				2'b00: slew_decode = `RLBV_SLEW_CODE0;
				2'b01: slew_decode = `RLBV_SLEW_CODE1;
				2'b10: slew_decode = `RLBV_SLEW_CODE2;
				default: slew_decode = `RLBV_SLEW_CODE3;
			endcase
		end
	endfunction

	function [3:0] step_decode;
		input coarse;
		begin
			step_decode = coarse ? `RLBV_STEP_COARSE_MV : `RLBV_STEP_FINE_MV;
		end
	endfunction

	// write strobes per register; unmapped addresses strobe nothing, so such writes are dropped
	wire wr_ctrl       = wr_en && (addr == `RLBV_ADDR_CTRL);
	wire wr_limit_b    = wr_en && (addr == `RLBV_ADDR_LIMIT_B);
	wire wr_limit_c    = wr_en && (addr == `RLBV_ADDR_LIMIT_C);
	wire wr_step_droop = wr_en && (addr == `RLBV_ADDR_STEP_DROOP);

	// bit 5 is stored as written; a host breaking the reserved value gets what it wrote back
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= `RLBV_RST_CTRL;
		end else if (wr_ctrl) begin
			ctrl_reg <= wr_data;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			limit_b_reg <= `RLBV_RST_LIMIT_B;
		end else if (wr_limit_b) begin
			limit_b_reg <= wr_data;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			limit_c_reg <= `RLBV_RST_LIMIT_C;
		end else if (wr_limit_c) begin
			limit_c_reg <= wr_data;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			step_droop_reg <= `RLBV_RST_STEP_DROOP;
		end else if (wr_step_droop) begin
			step_droop_reg <= wr_data;
		end
	end

	// unmapped addresses read as zero
	always @* begin
		case (addr)
			`RLBV_ADDR_CTRL:       rd_next = ctrl_reg;
			`RLBV_ADDR_LIMIT_B:    rd_next = limit_b_reg;
			`RLBV_ADDR_LIMIT_C:    rd_next = limit_c_reg;
			`RLBV_ADDR_STEP_DROOP: rd_next = step_droop_reg;
			default:               rd_next = 8'h00;
		endcase
	end

	// rd_valid is a one-cycle answer; rd_data holds the last read until the next strobe
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_en;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_data <= 8'h00;
		end else if (rd_en) begin
			rd_data <= rd_next;
		end
	end

	// next values of the decoded settings
	reg [8:0] rail_b_limit_next;
	reg [7:0] rail_c_limit_next;
	reg       rail_a_double_next;
	reg [7:0] rail_a_boot_next;
	reg [7:0] rail_b_boot_next;
	reg [7:0] rail_c_boot_next;
	reg [7:0] slew_next;
	reg [3:0] rail_a_step_next;
	reg [3:0] rail_b_step_next;
	reg [3:0] rail_c_step_next;
	reg       rail_a_droop_next;
	reg       rail_b_droop_next;
	reg       rail_c_droop_next;

	// boot values are level inputs, so a change there reaches the rail one cycle later
	always @* begin
		rail_b_limit_next  = ctrl_reg[`RLBV_BIT_B_DOUBLE] ?
			{limit_b_reg, 1'b0} : {1'b0, limit_b_reg};
		rail_c_limit_next  = limit_c_reg;
		rail_a_double_next = ctrl_reg[`RLBV_BIT_A_DOUBLE];
		rail_a_boot_next   = ctrl_reg[`RLBV_BIT_A_BOOT_EN] ? rail_a_boot_value : 8'h00;
		rail_b_boot_next   = ctrl_reg[`RLBV_BIT_B_BOOT_EN] ? rail_b_boot_value : 8'h00;
		rail_c_boot_next   = ctrl_reg[`RLBV_BIT_C_BOOT_EN] ? rail_c_boot_value : 8'h00;
		slew_next          = slew_decode(
			{ctrl_reg[`RLBV_BIT_SLEW_HI], ctrl_reg[`RLBV_BIT_SLEW_LO]});
		rail_a_step_next   = step_decode(step_droop_reg[`RLBV_BIT_A_STEP]);
		rail_b_step_next   = step_decode(step_droop_reg[`RLBV_BIT_B_STEP]);
		rail_c_step_next   = step_decode(step_droop_reg[`RLBV_BIT_C_STEP]);
		rail_a_droop_next  = step_droop_reg[`RLBV_BIT_A_DROOP];
		rail_b_droop_next  = step_droop_reg[`RLBV_BIT_B_DROOP];
		rail_c_droop_next  = step_droop_reg[`RLBV_BIT_C_DROOP];
	end

	// settings are registered so outputs come from flops; one cycle behind the store
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rail_b_limit_amps   <= 9'h000;
			rail_c_limit_amps   <= 8'h00;
			rail_a_limit_double <= 1'b0;
		end else begin
			rail_b_limit_amps   <= rail_b_limit_next;
			rail_c_limit_amps   <= rail_c_limit_next;
			rail_a_limit_double <= rail_a_double_next;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			rail_a_boot_voltage <= 8'h00;
			rail_b_boot_voltage <= 8'h00;
			rail_c_boot_voltage <= 8'h00;
		end else begin
			rail_a_boot_voltage <= rail_a_boot_next;
			rail_b_boot_voltage <= rail_b_boot_next;
			rail_c_boot_voltage <= rail_c_boot_next;
		end
	end

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			fast_slew_mv_per_us  <= 8'h00;
			rail_a_step_mv       <= 4'h0;
			rail_b_step_mv       <= 4'h0;
			rail_c_step_mv       <= 4'h0;
			rail_a_flat_droop_en <= 1'b0;
			rail_b_flat_droop_en <= 1'b0;
			rail_c_flat_droop_en <= 1'b0;
		end else begin
			fast_slew_mv_per_us  <= slew_next;
			rail_a_step_mv       <= rail_a_step_next;
			rail_b_step_mv       <= rail_b_step_next;
			rail_c_step_mv       <= rail_c_step_next;
			rail_a_flat_droop_en <= rail_a_droop_next;
			rail_b_flat_droop_en <= rail_b_droop_next;
			rail_c_flat_droop_en <= rail_c_droop_next;
		end
	end

endmodule

// ### test/rlbv_host.sv
// host model issuing register writes and reads
`timescale 1ns/1ns
module rlbv_host (
	input  wire       clk,
	output reg        wr_en,
	output reg        rd_en,
	output reg  [7:0] addr,
	output reg  [7:0] wr_data,
	input  wire [7:0] rd_data
);
	initial {wr_en, rd_en, addr, wr_data} = 18'h0_0000;
	// extra cycle after a write so decoded outputs have settled
	task wr(input [7:0] a, input [7:0] d);
		@(negedge clk) {wr_en, addr, wr_data} = {1'h1, a, a == 8'h11 ? d | 8'h20 : d};
		@(negedge clk) wr_en = 1'h0;
		@(negedge clk);
	endtask
	task rd(input [7:0] a, output [7:0] q);
		@(negedge clk) {rd_en, addr} = {1'h1, a};
		@(negedge clk) rd_en = 1'h0;
		q = rd_data;
	endtask
endmodule

// ### test/rlbv_regs_sva.sv
// checker on the config slice ports
`timescale 1ns/1ns
module rlbv_chk (
	input wire       clk, rst, wr_en, rd_en, rd_valid,
	input wire [7:0] addr, wr_data, rd_data, rail_a_boot_value, rail_a_boot_voltage,
	input wire [7:0] rail_c_limit_amps, fast_slew_mv_per_us,
	input wire [8:0] rail_b_limit_amps,
	input wire [3:0] rail_b_step_mv
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	wire wk = wr_en && addr == 8'h11;
	wire wb = wr_en && addr == 8'h12;
	wire wc = wr_en && addr == 8'h13;
	wire wv = wr_en && addr == 8'h14;
	a_rd_pulse: assert property (rd_en |=> rd_valid) else $error("no read valid");
	a_rd_cause: assert property (rd_valid |-> $past(rd_en)) else $error("stray valid");
	a_rd_unmapped: assert property (rd_en && (addr < 8'h11 || addr > 8'h14) |=> !rd_data)
		else $error("unmapped read");
	a_c_limit: assert property (wc |-> ##2 rail_c_limit_amps == $past(wr_data, 2))
		else $error("rail c limit");
	reg dbl = 1'h0;
	always @(posedge clk or posedge rst) if (rst) dbl <= 1'h0; else if (wk) dbl <= wr_data[6];
	a_b_limit_scale: assert property (wb |-> ##2 rail_b_limit_amps == ($past(dbl) ?
		{$past(wr_data, 2), 1'h0} : {1'h0, $past(wr_data, 2)})) else $error("rail b limit");
	a_slew_decode: assert property (wk |-> ##2 fast_slew_mv_per_us == ($past(wr_data[1:0], 2) ?
		8'h0c * ($past(wr_data[1:0], 2) + 8'h01) : 8'h0a)) else $error("slew code");
	a_boot_a_sel: assert property (wk |-> ##2 rail_a_boot_voltage ==
		($past(wr_data[4], 2) ? $past(rail_a_boot_value) : 8'h00)) else $error("boot a");
	a_b_step_size: assert property (wv |-> ##2 rail_b_step_mv ==
		($past(wr_data[6], 2) ? 4'ha : 4'h5)) else $error("step b");
	cover property (wk && wr_data[6]);
	cover property (wv && wr_data[7]);
	cover property (rd_en && addr == 8'h10);
endmodule
bind rlbv_regs rlbv_chk u_chk (.*);

// ### test/tb_rlbv_regs.sv
// self-checking bench for the config slice
`timescale 1ns/1ns
module tb_rlbv_regs;
	reg        clk = 1'h0, rst = 1'h1;
	wire       wr_en, rd_en, rd_valid, rail_a_limit_double;
	wire       rail_a_flat_droop_en, rail_b_flat_droop_en, rail_c_flat_droop_en;
	wire [7:0] addr, wr_data, rd_data, rail_c_limit_amps, fast_slew_mv_per_us;
	wire [7:0] rail_a_boot_voltage, rail_b_boot_voltage, rail_c_boot_voltage;
	wire [7:0] rail_a_boot_value = 8'h5a, rail_b_boot_value = 8'h3c, rail_c_boot_value = 8'hc3;
	wire [8:0] rail_b_limit_amps;
	wire [3:0] rail_a_step_mv, rail_b_step_mv, rail_c_step_mv;
	reg  [7:0] q;
	integer    n_mismatch = 0, checked = 0, i;
	localparam [31:0] RV = 32'h2251_2800, SL = 32'h0a18_2430;
	initial forever #2 clk = ~clk;
	rlbv_host host (.*);
	rlbv_regs dut (.*);
	task cmp(input [15:0] g, input [15:0] e);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task final_report;
		$display("mismatches %0d checks %0d", n_mismatch, checked);
		if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (4) @(negedge clk);
		rst = 1'h0;
		for (i = 0; i < 4; i++) begin
			host.rd(8'h11 + i, q);
			cmp(q, RV[31-8*i -: 8]);
		end
		cmp(rd_valid, 1'h1);
		host.wr(8'h12, 8'hff);
		for (i = 0; i < 4; i++) begin
			host.wr(8'h11, {1'h0, i[0], 1'h1, i[0], i[1], ~i[0], i[1:0]});
			cmp(rail_b_limit_amps, i[0] ? 9'h1fe : 9'h0ff);
			cmp(fast_slew_mv_per_us, SL[31-8*i -: 8]);
			cmp(rail_a_boot_voltage, i[0] ? 8'h5a : 8'h00);
			cmp(rail_b_boot_voltage, i[1] ? 8'h3c : 8'h00);
			cmp(rail_c_boot_voltage, i[0] ? 8'h00 : 8'hc3);
		end
		host.wr(8'h11, 8'ha2);
		cmp(rail_a_limit_double, 1'h1);
		cmp(rail_b_limit_amps, 9'h0ff);
		host.wr(8'h13, 8'h00);
		cmp(rail_c_limit_amps, 8'h00);
		host.wr(8'h14, 8'ha8);
		cmp({rail_a_step_mv, rail_b_step_mv, rail_c_step_mv, 1'h0, rail_a_flat_droop_en,
			rail_b_flat_droop_en, rail_c_flat_droop_en}, 16'ha5a2);
		host.rd(8'h14, q);
		cmp(q, 8'ha8);
		host.wr(8'h10, 8'h77);
		host.rd(8'h10, q);
		cmp(q, 8'h00);
		// second reset in mid-run must restore defaults
		rst = 1'h1;
		@(negedge clk) rst = 1'h0;
		host.rd(8'h14, q);
		cmp(q, 8'h00);
		cmp({rail_a_step_mv, rail_b_step_mv, rail_c_step_mv, 1'h0, rail_a_flat_droop_en,
			rail_b_flat_droop_en, rail_c_flat_droop_en}, 16'h5550);
		cmp({rail_a_limit_double, rail_b_limit_amps}, 10'h051);
		final_report;
	end
endmodule
